//--- rtl/iwwo_cfg.svh
`ifndef IWWO_CFG_SVH
`define IWWO_CFG_SVH

// ---------------------------------------------------------------
// opcodes
// ---------------------------------------------------------------
`define IWWO_OP_UEGI_EN   8'h33
`define IWWO_OP_WAIT      8'h36
`define IWWO_OP_WDT_RFR   8'h82
`define IWWO_OP_WDT_SLP   8'h83
`define IWWO_OP_UDGI_DIS  8'h32
`define IWWO_OP_MST_DIS   8'h34
`define IWWO_OP_MST_EN    8'h35

// ---------------------------------------------------------------
// cycle counts per instruction
// ---------------------------------------------------------------
`define IWWO_CYC_FAST     5'h07
`define IWWO_CYC_SLOW     5'h10
`define IWWO_CYC_RFR      5'h07
`define IWWO_CYC_SLP      5'h06

// ---------------------------------------------------------------
// watchdog
// ---------------------------------------------------------------
`define IWWO_WDT_W        8
`define IWWO_WDT_RST      8'h00
`define IWWO_WDT_PRE      8'h0a

`endif

//--- rtl/iwwo_pkg.sv
package iwwo_pkg;
    typedef enum logic [2:0] {
        IWWO_IDLE = 3'b000,
        IWWO_BUSY = 3'b001,
        IWWO_WAIT = 3'b011
    } iwwo_state_t;
endpackage

//--- rtl/iwwo_wdt.sv
`timescale 1ns/1ps
`include "iwwo_cfg.svh"

// watchdog counter: counts down on tick, frozen while disabled
module iwwo_wdt (
    input  wire logic                   sys_clk_i,
    input  wire logic                   nrst_i,
    input  wire logic                   load_i,
    input  wire logic                   stop_i,
    input  wire logic [`IWWO_WDT_W-1:0] cfg_count_i,
    output logic                        enabled_o,
    output logic                        expire_o
);
    logic [7:0]             pre;
    logic [7:0]             next_pre;
    logic [`IWWO_WDT_W-1:0] cnt;
    logic [`IWWO_WDT_W-1:0] next_cnt;
    logic                   en;
    logic                   next_en;
    logic                   next_exp;
    logic                   tick;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        tick     = (pre == 8'h00);
        next_pre = tick ? `IWWO_WDT_PRE : pre - 8'h01;
        next_cnt = cnt;
        next_en  = en;
        next_exp = 1'b0;
        if (load_i) begin
            next_en  = 1'b1;
            next_cnt = cfg_count_i;
            next_pre = `IWWO_WDT_PRE;
        end else if (stop_i) begin
            next_en = 1'b0;
        end else if (en && tick) begin
            if (cnt == 8'h00) begin
                next_exp = 1'b1;
                next_en  = 1'b0;
            end else begin
                next_cnt = cnt - 8'h01;
            end
        end
    end

    // registers
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pre       <= 8'h00;
            cnt       <= `IWWO_WDT_RST;
            en        <= 1'b0;
            expire_o  <= 1'b0;
        end else begin
            pre       <= next_pre;
            cnt       <= next_cnt;
            en        <= next_en;
            expire_o  <= next_exp;
        end
    end

    assign enabled_o = en;
endmodule

//--- rtl/iwwo_core.sv
`timescale 1ns/1ps
`include "iwwo_cfg.svh"

module iwwo_core (
    input  wire logic        sys_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        op_valid_i,
    input  wire logic [7:0]  opcode_i,
    input  wire logic [7:0]  cfg_reg2_i,
    input  wire logic        irq_req_i,
    input  wire logic        irq_src_active_i,
    output logic             busy_o,
    output logic             fetch_stall_o,
    output logic             power_down_o,
    output logic             global_irq_mask_o,
    output logic             master_disable_o,
    output logic             wdt_enabled_o,
    output logic             wdt_reset_o,
    output logic             flags_we_o
);
    iwwo_pkg::iwwo_state_t state;
    iwwo_pkg::iwwo_state_t next_state;
    logic [4:0]            cnt;
    logic [4:0]            next_cnt;
    logic                  mask;
    logic                  next_mask;
    logic                  mdis;
    logic                  next_mdis;
    logic                  next_wait;
    logic                  wait_dead;
    logic                  next_dead;
    logic                  wdt_load;
    logic                  wdt_stop;
    logic                  wdt_en;
    logic                  wdt_exp;
    logic                  take;

    // ---------------------------------------------------------------
    // decode and sequencing
    // ---------------------------------------------------------------
    function automatic logic is_op(input logic [7:0] op,
                                   input logic [7:0] code);
        return op == code;
    endfunction

    always_comb begin
        take       = op_valid_i && (state == iwwo_pkg::IWWO_IDLE);
        next_state = state;
        next_cnt   = cnt;
        next_mask  = mask;
        next_mdis  = mdis;
        next_dead  = wait_dead;
        next_wait  = 1'b0;
        wdt_load   = 1'b0;
        wdt_stop   = 1'b0;
        case (state)
            iwwo_pkg::IWWO_IDLE: begin
                if (take) begin
                    next_state = iwwo_pkg::IWWO_BUSY;
                    next_cnt   = mask ? `IWWO_CYC_FAST
                                      : `IWWO_CYC_SLOW;
                    if (is_op(opcode_i, `IWWO_OP_UEGI_EN)) begin
                        next_mask = !mdis;
                    end else if (is_op(opcode_i, `IWWO_OP_UDGI_DIS)) begin
                        next_mask = 1'b0;
                    end else if (is_op(opcode_i, `IWWO_OP_MST_DIS)) begin
                        next_mdis = 1'b1;
                        next_mask = 1'b0;
                    end else if (is_op(opcode_i, `IWWO_OP_MST_EN)) begin
                        next_mdis = 1'b0;
                    end else if (is_op(opcode_i, `IWWO_OP_WAIT)) begin
                        next_wait = 1'b1;
                        next_dead = !irq_src_active_i;
                    end else if (is_op(opcode_i, `IWWO_OP_WDT_RFR)) begin
                        wdt_load = 1'b1;
                        next_cnt = `IWWO_CYC_RFR;
                    end else if (is_op(opcode_i, `IWWO_OP_WDT_SLP)) begin
                        wdt_stop = 1'b1;
                        next_cnt = `IWWO_CYC_SLP;
                    end else begin
                        next_state = iwwo_pkg::IWWO_IDLE;  // not ours
                    end
                    if (next_wait) begin
                        next_state = iwwo_pkg::IWWO_WAIT;
                    end
                end
            end
            iwwo_pkg::IWWO_BUSY: begin
                // count includes the decode cycle
                if (cnt <= 5'h02) begin
                    next_state = iwwo_pkg::IWWO_IDLE;
                end else begin
                    next_cnt = cnt - 5'h01;
                end
            end
            iwwo_pkg::IWWO_WAIT: begin
                // a dead wait ignores all requests until reset
                if (irq_req_i && !wait_dead) begin
                    next_state = iwwo_pkg::IWWO_BUSY;
                end
            end
            default: begin
                next_state = iwwo_pkg::IWWO_IDLE;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // state registers and outputs
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state             <= iwwo_pkg::IWWO_IDLE;
            cnt               <= 5'h00;
            mask              <= 1'b0;
            mdis              <= 1'b0;
            wait_dead         <= 1'b0;
            busy_o            <= 1'b0;
            fetch_stall_o     <= 1'b0;
            power_down_o      <= 1'b0;
            global_irq_mask_o <= 1'b0;
            master_disable_o  <= 1'b0;
            wdt_reset_o       <= 1'b0;
            wdt_enabled_o     <= 1'b0;
            flags_we_o        <= 1'b0;
        end else begin
            state             <= next_state;
            cnt               <= next_cnt;
            mask              <= next_mask;
            mdis              <= next_mdis;
            wait_dead         <= next_dead;
            busy_o            <= next_state != iwwo_pkg::IWWO_IDLE;
            fetch_stall_o     <= next_state == iwwo_pkg::IWWO_WAIT;
            power_down_o      <= next_state == iwwo_pkg::IWWO_WAIT;
            global_irq_mask_o <= next_mask;
            master_disable_o  <= next_mdis;
            wdt_reset_o       <= wdt_exp;
            wdt_enabled_o     <= wdt_en;
            flags_we_o        <= 1'b0;
        end
    end

    // watchdog loads from configuration register 2
    iwwo_wdt u_wdt (
        .sys_clk_i   (sys_clk_i),
        .nrst_i      (nrst_i),
        .load_i      (wdt_load),
        .stop_i      (wdt_stop),
        .cfg_count_i (cfg_reg2_i),
        .enabled_o   (wdt_en),
        .expire_o    (wdt_exp)
    );
endmodule

//--- tb/iwwo_core_assertions.sv
`timescale 1ns/1ps
`include "iwwo_cfg.svh"
// ---------------------------------------------
// core checker
// ---------------------------------------------
module iwwo_chk (
    input wire logic       sys_clk_i,
    input wire logic       nrst_i,
    input wire logic       op_valid_i,
    input wire logic [7:0] opcode_i,
    input wire logic       irq_req_i,
    input wire logic       irq_src_active_i,
    input wire logic       busy_o,
    input wire logic       fetch_stall_o,
    input wire logic       power_down_o,
    input wire logic       global_irq_mask_o,
    input wire logic       master_disable_o,
    input wire logic       wdt_enabled_o,
    input wire logic       wdt_reset_o,
    input wire logic       flags_we_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    // an op is only taken while idle
    wire logic       tk;
    wire logic [7:0] op;
    assign tk = op_valid_i && !busy_o;
    assign op = opcode_i;
    // a wait entered with no live source can only end by reset
    logic dead_seen;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dead_seen <= 1'b0;
        end else if (tk && op == `IWWO_OP_WAIT) begin
            dead_seen <= !irq_src_active_i;
        end
    end
    flags_kept_a: assert property (!flags_we_o)
        else $error("flags written");
    uegi_set_a: assert property (tk && op == `IWWO_OP_UEGI_EN &&
        !master_disable_o |=> global_irq_mask_o) else $error("mask not set");
    uegi_block_a: assert property (tk && op == `IWWO_OP_UEGI_EN &&
        master_disable_o |=> !global_irq_mask_o) else $error("mask set");
    fast_len_a: assert property (tk && op == `IWWO_OP_UEGI_EN &&
        global_irq_mask_o |=> busy_o[*6] ##1 !busy_o) else $error("fast len");
    slow_len_a: assert property (tk && op == `IWWO_OP_UEGI_EN &&
        !global_irq_mask_o |=> busy_o[*8] ##1 busy_o[*7] ##1 !busy_o)
        else $error("slow len");
    wait_enter_a: assert property (tk && op == `IWWO_OP_WAIT
        |=> fetch_stall_o && power_down_o) else $error("no wait");
    wait_hold_a: assert property (fetch_stall_o && !irq_req_i
        |=> fetch_stall_o && power_down_o) else $error("left wait");
    wait_exit_a: assert property (fetch_stall_o && irq_req_i
        && !dead_seen |=> !fetch_stall_o && !power_down_o)
        else $error("stuck in wait");
    wait_dead_a: assert property (fetch_stall_o && dead_seen
        |=> fetch_stall_o && power_down_o) else $error("dead wait left");
    rfr_on_a: assert property (tk && op == `IWWO_OP_WDT_RFR
        |=> ##[0:2] wdt_enabled_o) else $error("wdt not on");
    slp_off_a: assert property (tk && op == `IWWO_OP_WDT_SLP
        |=> busy_o[*5] ##1 (!busy_o && !wdt_enabled_o)) else $error("wdt on");
    rst_pulse_a: assert property (wdt_reset_o
        |=> !wdt_reset_o ##[0:1] !wdt_enabled_o) else $error("bad pulse");
    udgi_clr_a: assert property (tk && op == `IWWO_OP_UDGI_DIS
        |=> !global_irq_mask_o) else $error("mask kept");
    c_wake: cover property (fetch_stall_o && irq_req_i);
    c_wdt: cover property (wdt_reset_o);
    c_slow: cover property (tk && op == `IWWO_OP_UEGI_EN
        && !global_irq_mask_o);
    c_dead: cover property (fetch_stall_o && dead_seen && irq_req_i);
endmodule
bind iwwo_core iwwo_chk u_chk (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i),
    .op_valid_i(op_valid_i), .opcode_i(opcode_i), .irq_req_i(irq_req_i),
    .irq_src_active_i(irq_src_active_i),
    .busy_o(busy_o), .fetch_stall_o(fetch_stall_o),
    .power_down_o(power_down_o), .global_irq_mask_o(global_irq_mask_o),
    .master_disable_o(master_disable_o), .wdt_enabled_o(wdt_enabled_o),
    .wdt_reset_o(wdt_reset_o), .flags_we_o(flags_we_o));

//--- tb/testbench.sv
`timescale 1ns/1ps
`include "iwwo_cfg.svh"
// ---------------------------------------------
// bench
// ---------------------------------------------
module testbench;
    typedef struct {logic [7:0] op; int m; int d; int c;} iwwo_row_t;
    logic       clk = 0, nrst = 0, vld = 0, irq = 0, act = 1;
    logic [7:0] opc = 8'h00, cfg = 8'h03;
    logic       busy, stall, pd, mask, mdis, wen, wrst, fwe;
    int         mismatches = 0, n_checks = 0, n, pulses = 0, p0, exp_n;
    // -1 skips the m or c field; mask starts clear after reset
    iwwo_row_t  rows [6] = '{'{`IWWO_OP_UEGI_EN, 1, 0, 15},
        '{`IWWO_OP_UEGI_EN, 1, 0, 6}, '{`IWWO_OP_UDGI_DIS, 0, 0, -1},
        '{`IWWO_OP_MST_DIS, 0, 1, -1}, '{`IWWO_OP_UEGI_EN, 0, 1, 15},
        '{`IWWO_OP_MST_EN, -1, 0, -1}};
    iwwo_core u_iwwo_core (.sys_clk_i(clk), .nrst_i(nrst), .op_valid_i(vld),
        .opcode_i(opc), .cfg_reg2_i(cfg), .irq_req_i(irq),
        .irq_src_active_i(act), .busy_o(busy), .fetch_stall_o(stall),
        .power_down_o(pd), .global_irq_mask_o(mask),
        .master_disable_o(mdis), .wdt_enabled_o(wen), .wdt_reset_o(wrst),
        .flags_we_o(fwe));
    // clock and chip reset pulse counter
    always #50 clk = ~clk;
    always @(posedge clk) if (wrst === 1'b1) pulses <= pulses + 1;
    task chk(input string s, input logic [15:0] seen, input logic [15:0] e);
        n_checks++;
        if (seen !== e) begin
            mismatches++;
            $display("Error %s exp %h seen %h", s, e, seen);
        end
    endtask
    // inputs always move 5 ns after the edge
    task tick; @(posedge clk); #5; endtask
    task issue(input logic [7:0] op); vld = 1; opc = op; tick; vld = 0;
    endtask
    task idle; n = 0; while (busy === 1'b1 && n < 300) begin n++; tick; end
        if (n >= 300) mismatches++;
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // hang guard, about seven times the expected run
    initial begin #400000; mismatches++; finish_test; end
    initial begin
        repeat (3) @(posedge clk);
        #5 nrst = 1;
        tick;
        chk("reset", {busy, mask, mdis, wen, wrst, fwe}, 16'h0000);
        foreach (rows[i]) begin
            issue(rows[i].op);
            idle;
            if (rows[i].c >= 0) chk("cycles", 16'(n), 16'(rows[i].c));
            if (rows[i].m >= 0)
                chk("mask", mask, rows[i].m[0]);
            chk("mdis", mdis, rows[i].d[0]);
            $display("row %0d done", i);
        end
        issue(`IWWO_OP_WAIT);
        repeat (20) tick;
        chk("wait", {stall, pd, busy}, 16'h0007);
        irq = 1;
        tick;
        irq = 0;
        chk("wake", {stall, pd}, 16'h0000);
        idle;
        chk("wake cycles", 16'(n), 16'h000f);
        $display("wait test done");
        // a second refresh mid-count must push the chip reset out
        issue(`IWWO_OP_WDT_RFR);
        idle;
        chk("rfr cycles", 16'(n), 16'h0006);
        chk("wdt on", wen, 1'b1);
        repeat (25) tick;
        // a new load value shows where the reloaded count comes from
        cfg = 8'h05;
        issue(`IWWO_OP_WDT_RFR);
        idle;
        chk("wdt kept", wen, 1'b1);
        n = 0;
        while (pulses == 0 && n < 200) begin n++; tick; end
        // cfg+1 ticks, pulse two clocks late, six busy clocks already gone
        exp_n = (`IWWO_WDT_PRE + 1) * (cfg + 1) - 4;
        chk("reload", 16'(n), 16'(exp_n));
        tick;
        chk("wdt off", wen, 1'b0);
        issue(`IWWO_OP_WDT_RFR);
        idle;
        issue(`IWWO_OP_WDT_SLP);
        idle;
        chk("slp cycles", 16'(n), 16'h0005);
        p0 = pulses;
        repeat (200) tick;
        chk("frozen", 16'(pulses - p0), 16'h0000);
        $display("watchdog test done");
        act = 0;
        issue(`IWWO_OP_WAIT);
        // a request must not wake a wait entered with no live source
        irq = 1;
        repeat (100) tick;
        chk("no wake", {stall, pd}, 16'h0003);
        nrst = 0;
        irq = 0;
        tick;
        nrst = 1;
        tick;
        chk("re-reset", {busy, stall, pd}, 16'h0000);
        $display("reset test done");
        finish_test;
    end
endmodule
